// [common/ppd_pkg.sv]
// Package with constants and carrier types of the pulse pattern data registers
package ppd_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int DW     = 8;
    localparam int AW     = 4;
    localparam int GROUPS = 4;
    localparam int NIB    = 4;
    localparam int CH     = 4;
    localparam int SEL_W  = 2;
    localparam int PINS   = 16;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [AW-1:0] ADDR_EN_HI   = 4'h0;
    localparam logic [AW-1:0] ADDR_EN_LO   = 4'h1;
    localparam logic [AW-1:0] ADDR_CUR_HI  = 4'h2;
    localparam logic [AW-1:0] ADDR_CUR_LO  = 4'h3;
    localparam logic [AW-1:0] ADDR_NXT_HI_A = 4'h4;
    localparam logic [AW-1:0] ADDR_NXT_LO_A = 4'h5;
    localparam logic [AW-1:0] ADDR_NXT_HI_B = 4'h6;
    localparam logic [AW-1:0] ADDR_NXT_LO_B = 4'h7;
    localparam logic [AW-1:0] ADDR_TRIG_SEL = 4'h8;
    localparam logic [AW-1:0] ADDR_MODE    = 4'h9;

    // ------------------------------------------------------------------
    // Reset values and field layout
    // ------------------------------------------------------------------
    localparam logic [DW-1:0]  RST_ZERO     = 8'h00;
    localparam logic [DW-1:0]  RST_TRIG_SEL = 8'hFF;
    localparam logic [DW-1:0]  RST_MODE     = 8'hF0;
    localparam logic [NIB-1:0] NIB_ONES     = 4'hF;
    localparam logic [PINS-1:0] PINS_ZERO   = 16'h0000;
    localparam int MODE_INV_LSB = 4;
    localparam int MODE_NOV_LSB = 0;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [CH-1:0] a;
        logic [CH-1:0] b;
    } ppd_cmp_t;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic          wr;
        logic          rd;
    } ppd_bus_t;

endpackage

// [src/ppd_trig_sel.sv]
// Output trigger selection for one pulse group
module ppd_trig_sel (
    input  wire ppd_pkg::ppd_cmp_t       cmp,  // Compare match events
    input  wire logic [ppd_pkg::SEL_W-1:0] sel, // Channel selector
    input  wire logic                    nov,  // Non-overlap mode
    output logic                         trig  // Group trigger pulse
);

    // Match A always triggers; match B only in non-overlap mode
    assign trig = cmp.a[sel] | (nov & cmp.b[sel]);

endmodule

// [src/ppd_nib_split.sv]
// Shared or nibble-split mapping of one next-pattern register
module ppd_nib_split (
    input  wire logic [ppd_pkg::DW-1:0] cur,     // Stored next pattern
    input  wire logic                   shared,  // Both groups share a trigger
    input  wire logic                   wr_a,    // Write at first address
    input  wire logic                   wr_b,    // Write at second address
    input  wire logic [ppd_pkg::DW-1:0] wdata,   // Write data
    output logic      [ppd_pkg::DW-1:0] nxt,     // Next stored value
    output logic      [ppd_pkg::DW-1:0] rdata_a, // Read view at first address
    output logic      [ppd_pkg::DW-1:0] rdata_b  // Read view at second address
);

    logic wr_up;
    logic wr_lo;

    // Shared: whole byte at first address; split: one nibble per address
    assign wr_up = wr_a;
    assign wr_lo = shared ? wr_a : wr_b;

    assign nxt[7:4] = wr_up ? wdata[7:4] : cur[7:4];
    assign nxt[3:0] = wr_lo ? wdata[3:0] : cur[3:0];

    // Unused nibbles read as ones in split mode
    assign rdata_a = shared ? cur : {cur[7:4], ppd_pkg::NIB_ONES};
    assign rdata_b = shared ? ppd_pkg::RST_ZERO : {ppd_pkg::NIB_ONES, cur[3:0]};

endmodule

// [src/ppd_data_regs.sv]
// Pulse pattern data registers: current output, next pattern, enables and triggers
module ppd_data_regs (
    input  wire logic                     mclk,      // System clock
    input  wire logic                     rst,       // Asynchronous reset, active high
    input  wire logic [ppd_pkg::AW-1:0]   addr,      // Register address
    input  wire logic [ppd_pkg::DW-1:0]   wdata,     // Write data
    input  wire logic                     wr,        // Write strobe
    input  wire logic                     rd,        // Read strobe
    output logic      [ppd_pkg::DW-1:0]   rdata,     // Read data, cycle after strobe
    input  wire ppd_pkg::ppd_cmp_t        cmp_evt,   // Timer compare match pulses
    output logic      [ppd_pkg::PINS-1:0] pulse_out, // Pulse output pin levels
    output logic      [ppd_pkg::PINS-1:0] pulse_oe   // Pulse output enables
);

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    ppd_pkg::ppd_bus_t bus;
    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    logic [ppd_pkg::DW-1:0] en_hi_reg;
    logic [ppd_pkg::DW-1:0] en_lo_reg;
    logic [ppd_pkg::DW-1:0] cur_hi_reg;
    logic [ppd_pkg::DW-1:0] cur_lo_reg;
    logic [ppd_pkg::DW-1:0] nxt_hi_reg;
    logic [ppd_pkg::DW-1:0] nxt_lo_reg;
    logic [ppd_pkg::DW-1:0] trig_sel_reg;
    logic [ppd_pkg::DW-1:0] mode_reg;
    logic [ppd_pkg::DW-1:0] rdata_reg;
    logic [ppd_pkg::PINS-1:0] pin_reg;
    logic [ppd_pkg::PINS-1:0] oe_reg;

    wire wr_en_hi  = bus.wr && (bus.addr == ppd_pkg::ADDR_EN_HI);
    wire wr_en_lo  = bus.wr && (bus.addr == ppd_pkg::ADDR_EN_LO);
    wire wr_cur_hi = bus.wr && (bus.addr == ppd_pkg::ADDR_CUR_HI);
    wire wr_cur_lo = bus.wr && (bus.addr == ppd_pkg::ADDR_CUR_LO);
    wire wr_nhi_a  = bus.wr && (bus.addr == ppd_pkg::ADDR_NXT_HI_A);
    wire wr_nlo_a  = bus.wr && (bus.addr == ppd_pkg::ADDR_NXT_LO_A);
    wire wr_nhi_b  = bus.wr && (bus.addr == ppd_pkg::ADDR_NXT_HI_B);
    wire wr_nlo_b  = bus.wr && (bus.addr == ppd_pkg::ADDR_NXT_LO_B);
    wire wr_trig   = bus.wr && (bus.addr == ppd_pkg::ADDR_TRIG_SEL);
    wire wr_mode   = bus.wr && (bus.addr == ppd_pkg::ADDR_MODE);

    // Groups of one register share a trigger when their selectors match
    wire shared_hi = (trig_sel_reg[3*ppd_pkg::SEL_W +: ppd_pkg::SEL_W]
                   == trig_sel_reg[2*ppd_pkg::SEL_W +: ppd_pkg::SEL_W]);
    wire shared_lo = (trig_sel_reg[1*ppd_pkg::SEL_W +: ppd_pkg::SEL_W]
                   == trig_sel_reg[0*ppd_pkg::SEL_W +: ppd_pkg::SEL_W]);

    // ------------------------------------------------------------------
    // Next-pattern address mapping
    // ------------------------------------------------------------------
    logic [ppd_pkg::DW-1:0] nxt_hi_next;
    logic [ppd_pkg::DW-1:0] nxt_lo_next;
    logic [ppd_pkg::DW-1:0] nhi_rd_a;
    logic [ppd_pkg::DW-1:0] nhi_rd_b;
    logic [ppd_pkg::DW-1:0] nlo_rd_a;
    logic [ppd_pkg::DW-1:0] nlo_rd_b;

    ppd_nib_split u_map_hi (
        .cur     (nxt_hi_reg),
        .shared  (shared_hi),
        .wr_a    (wr_nhi_a),
        .wr_b    (wr_nhi_b && !shared_hi),
        .wdata   (bus.wdata),
        .nxt     (nxt_hi_next),
        .rdata_a (nhi_rd_a),
        .rdata_b (nhi_rd_b)
    );

    ppd_nib_split u_map_lo (
        .cur     (nxt_lo_reg),
        .shared  (shared_lo),
        .wr_a    (wr_nlo_a),
        .wr_b    (wr_nlo_b && !shared_lo),
        .wdata   (bus.wdata),
        .nxt     (nxt_lo_next),
        .rdata_a (nlo_rd_a),
        .rdata_b (nlo_rd_b)
    );

    // ------------------------------------------------------------------
    // Trigger selection per group
    // ------------------------------------------------------------------
    logic [ppd_pkg::GROUPS-1:0] grp_trig;

    genvar g;
    generate
        for (g = 0; g < ppd_pkg::GROUPS; g = g + 1)
        begin : g_grp
            ppd_trig_sel u_sel (
                .cmp  (cmp_evt),
                .sel  (trig_sel_reg[g*ppd_pkg::SEL_W +: ppd_pkg::SEL_W]),
                .nov  (mode_reg[ppd_pkg::MODE_NOV_LSB + g]),
                .trig (grp_trig[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Per-bit transfer and current-output update
    // ------------------------------------------------------------------
    wire [ppd_pkg::PINS-1:0] en_all  = {en_hi_reg, en_lo_reg};
    wire [ppd_pkg::PINS-1:0] cur_all = {cur_hi_reg, cur_lo_reg};
    wire [ppd_pkg::PINS-1:0] nxt_all = {nxt_hi_reg, nxt_lo_reg};
    wire [ppd_pkg::PINS-1:0] wd_all  = {bus.wdata, bus.wdata};
    wire [ppd_pkg::PINS-1:0] wcur_all = {{ppd_pkg::DW{wr_cur_hi}}, {ppd_pkg::DW{wr_cur_lo}}};
    logic [ppd_pkg::PINS-1:0] xfer;
    logic [ppd_pkg::PINS-1:0] cur_next;
    logic [ppd_pkg::PINS-1:0] pin_next;

    genvar i;
    generate
        for (i = 0; i < ppd_pkg::PINS; i = i + 1)
        begin : g_bit
            // Only enabled bits follow their group's trigger
            assign xfer[i] = en_all[i] & grp_trig[i / ppd_pkg::NIB];
            // Transfer takes the stored pattern, not one written this cycle
            assign cur_next[i] = xfer[i] ? nxt_all[i]
                               : ((wcur_all[i] & ~en_all[i]) ? wd_all[i]
                               : cur_all[i]);
            // Mode bit one means direct output
            assign pin_next[i] = cur_all[i] ^ ~mode_reg[ppd_pkg::MODE_INV_LSB + i / ppd_pkg::NIB];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------------
    logic [ppd_pkg::DW-1:0] rd_mux;
    always_comb
    begin
        case (bus.addr)
            ppd_pkg::ADDR_EN_HI:    rd_mux = en_hi_reg;
            ppd_pkg::ADDR_EN_LO:    rd_mux = en_lo_reg;
            ppd_pkg::ADDR_CUR_HI:   rd_mux = cur_hi_reg;
            ppd_pkg::ADDR_CUR_LO:   rd_mux = cur_lo_reg;
            ppd_pkg::ADDR_NXT_HI_A: rd_mux = nhi_rd_a;
            ppd_pkg::ADDR_NXT_LO_A: rd_mux = nlo_rd_a;
            ppd_pkg::ADDR_NXT_HI_B: rd_mux = nhi_rd_b;
            ppd_pkg::ADDR_NXT_LO_B: rd_mux = nlo_rd_b;
            ppd_pkg::ADDR_TRIG_SEL: rd_mux = trig_sel_reg;
            ppd_pkg::ADDR_MODE:     rd_mux = mode_reg;
            default:                rd_mux = ppd_pkg::RST_ZERO;
        endcase
    end

    wire [ppd_pkg::DW-1:0] rdata_next = bus.rd ? rd_mux : ppd_pkg::RST_ZERO;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cur_hi_reg <= ppd_pkg::RST_ZERO;
            cur_lo_reg <= ppd_pkg::RST_ZERO;
            nxt_hi_reg <= ppd_pkg::RST_ZERO;
            nxt_lo_reg <= ppd_pkg::RST_ZERO;
        end
        else
        begin
            cur_hi_reg <= cur_next[15:8];
            cur_lo_reg <= cur_next[7:0];
            nxt_hi_reg <= nxt_hi_next;
            nxt_lo_reg <= nxt_lo_next;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            en_hi_reg    <= ppd_pkg::RST_ZERO;
            en_lo_reg    <= ppd_pkg::RST_ZERO;
            trig_sel_reg <= ppd_pkg::RST_TRIG_SEL;
            mode_reg     <= ppd_pkg::RST_MODE;
        end
        else
        begin
            en_hi_reg    <= wr_en_hi ? bus.wdata : en_hi_reg;
            en_lo_reg    <= wr_en_lo ? bus.wdata : en_lo_reg;
            trig_sel_reg <= wr_trig ? bus.wdata : trig_sel_reg;
            mode_reg     <= wr_mode ? bus.wdata : mode_reg;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rdata_reg <= ppd_pkg::RST_ZERO;
            pin_reg   <= ppd_pkg::PINS_ZERO;
            oe_reg    <= ppd_pkg::PINS_ZERO;
        end
        else
        begin
            rdata_reg <= rdata_next;
            pin_reg   <= pin_next;
            oe_reg    <= en_all;
        end
    end

    assign rdata     = rdata_reg;
    assign pulse_out = pin_reg;
    assign pulse_oe  = oe_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence seq_cur_hi_write;
        wr_cur_hi && !(|xfer[15:8]);
    endsequence

    sequence seq_nhi_split_write;
        wr_nhi_a && !shared_hi;
    endsequence

    sequence seq_cur_lo_write;
        wr_cur_lo && !(|xfer[7:0]);
    endsequence

    sequence seq_nlo_split_write;
        wr_nlo_a && !shared_lo;
    endsequence

    chk_cur_locked: assert property (seq_cur_hi_write |=>
        ((cur_hi_reg ^ $past(cur_hi_reg)) & $past(en_hi_reg)) == ppd_pkg::RST_ZERO)
        else $error("enabled current output bit changed by cpu write");

    chk_cur_write_free: assert property (wr_cur_lo |=>
        (cur_lo_reg & ~$past(en_lo_reg)) == ($past(bus.wdata) & ~$past(en_lo_reg)))
        else $error("free current output bit not written");

    chk_xfer_high: assert property ((|xfer[15:8]) |=>
        (cur_hi_reg & $past(xfer[15:8])) == ($past(nxt_hi_reg) & $past(xfer[15:8])))
        else $error("upper transfer took wrong value");

    chk_xfer_low: assert property ((|xfer[7:0]) |=>
        (cur_lo_reg & $past(xfer[7:0])) == ($past(nxt_lo_reg) & $past(xfer[7:0])))
        else $error("lower transfer took wrong value");

    chk_disabled_hold: assert property (!wr_cur_hi |=>
        ((cur_hi_reg ^ $past(cur_hi_reg)) & ~$past(en_hi_reg)) == ppd_pkg::RST_ZERO)
        else $error("disabled bit changed without write");

    chk_shared_full: assert property ((wr_nhi_a && shared_hi) |=> nxt_hi_reg == $past(bus.wdata))
        else $error("shared upper next write lost bits");

    chk_split_keep: assert property (seq_nhi_split_write |=>
        (nxt_hi_reg[3:0] == $past(nxt_hi_reg[3:0])) && (nxt_hi_reg[7:4] == $past(bus.wdata[7:4])))
        else $error("split upper write touched wrong nibble");

    chk_split_ones_hi: assert property ((bus.rd && bus.addr == ppd_pkg::ADDR_NXT_HI_A && !shared_hi) |=>
        rdata[3:0] == ppd_pkg::NIB_ONES)
        else $error("split upper unused nibble not ones");

    chk_split_ones_lo: assert property ((bus.rd && bus.addr == ppd_pkg::ADDR_NXT_LO_B && !shared_lo) |=>
        rdata[7:4] == ppd_pkg::NIB_ONES && rdata[3:0] == $past(nxt_lo_reg[3:0]))
        else $error("split lower read view wrong");

    chk_pin_invert: assert property (##1 pulse_out[15:12] ==
        ($past(cur_hi_reg[7:4]) ^ {ppd_pkg::NIB{~$past(mode_reg[ppd_pkg::MODE_INV_LSB + 3])}}))
        else $error("group three pin polarity wrong");

    chk_trig_select: assert property (grp_trig[0] ==
        |((cmp_evt.a | ({ppd_pkg::CH{mode_reg[ppd_pkg::MODE_NOV_LSB]}} & cmp_evt.b)) & (4'h1 << trig_sel_reg[1:0])))
        else $error("group zero trigger selection wrong");

    chk_match_b_ignored: assert property ((!mode_reg[ppd_pkg::MODE_NOV_LSB + 3] && cmp_evt.a == '0) |->
        !grp_trig[3])
        else $error("match b triggered group three in normal mode");

    chk_lock_low: assert property (seq_cur_lo_write |=>
        ((cur_lo_reg ^ $past(cur_lo_reg)) & $past(en_lo_reg)) == ppd_pkg::RST_ZERO)
        else $error("enabled low output bit changed by cpu write");

    chk_free_high: assert property (wr_cur_hi |=>
        (cur_hi_reg & ~$past(en_hi_reg)) == ($past(bus.wdata) & ~$past(en_hi_reg)))
        else $error("free upper output bit not written");

    chk_hold_low: assert property (!wr_cur_lo |=>
        ((cur_lo_reg ^ $past(cur_lo_reg)) & ~$past(en_lo_reg)) == ppd_pkg::RST_ZERO)
        else $error("disabled low bit changed without write");

    chk_shared_low: assert property ((wr_nlo_a && shared_lo) |=> nxt_lo_reg == $past(bus.wdata))
        else $error("shared lower next write lost bits");

    chk_split_low: assert property (seq_nlo_split_write |=>
        (nxt_lo_reg[3:0] == $past(nxt_lo_reg[3:0])) && (nxt_lo_reg[7:4] == $past(bus.wdata[7:4])))
        else $error("split lower write touched wrong nibble");

    chk_split_second: assert property ((wr_nhi_b && !shared_hi) |=>
        (nxt_hi_reg[7:4] == $past(nxt_hi_reg[7:4])) && (nxt_hi_reg[3:0] == $past(bus.wdata[3:0])))
        else $error("split upper second address wrote wrong nibble");

    chk_shared_unmapped: assert property ((wr_nhi_b && shared_hi) |=>
        nxt_hi_reg == $past(nxt_hi_reg))
        else $error("unmapped upper next address changed register");

    chk_ones_hi_b: assert property ((bus.rd && bus.addr == ppd_pkg::ADDR_NXT_HI_B && !shared_hi) |=>
        rdata[7:4] == ppd_pkg::NIB_ONES && rdata[3:0] == $past(nxt_hi_reg[3:0]))
        else $error("split upper second read view wrong");

    chk_ones_lo_a: assert property ((bus.rd && bus.addr == ppd_pkg::ADDR_NXT_LO_A && !shared_lo) |=>
        rdata[3:0] == ppd_pkg::NIB_ONES && rdata[7:4] == $past(nxt_lo_reg[7:4]))
        else $error("split lower first read view wrong");

    chk_cur_read: assert property ((bus.rd && bus.addr == ppd_pkg::ADDR_CUR_LO) |=>
        rdata == $past(cur_lo_reg))
        else $error("low current output read wrong");

    chk_rdata_idle: assert property (!bus.rd |=> rdata == ppd_pkg::RST_ZERO)
        else $error("read data not cleared outside read cycle");

    chk_pin_group0: assert property (##1 pulse_out[3:0] ==
        ($past(cur_lo_reg[3:0]) ^ {ppd_pkg::NIB{~$past(mode_reg[ppd_pkg::MODE_INV_LSB])}}))
        else $error("group zero pin polarity wrong");

endmodule

// [sim/ppd_timer_model.sv]
// Timer model that raises one compare match pulse on request, promptly or after a delay
module ppd_timer_model (
    input  wire logic         mclk,    // System clock
    input  wire logic         rst,     // Asynchronous reset, active high
    input  wire logic         req,     // Request one compare match
    input  wire logic [1:0]   req_ch,  // Timer channel of the match
    input  wire logic         req_b,   // Match B instead of match A
    input  wire logic [3:0]   req_dly, // Idle cycles before the match
    output ppd_pkg::ppd_cmp_t cmp_evt  // Compare match pulses
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] dly_reg;
    logic       pend_reg;
    logic [1:0] ch_reg;
    logic       b_reg;

    // Match pulses last exactly one cycle, as a real timer gives them
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cmp_evt  <= 8'h00;
            dly_reg  <= 4'h0;
            pend_reg <= 1'b0;
            ch_reg   <= 2'h0;
            b_reg    <= 1'b0;
        end
        else
        begin
            cmp_evt <= 8'h00;
            if (req)
            begin
                pend_reg <= 1'b1;
                dly_reg  <= req_dly;
                ch_reg   <= req_ch;
                b_reg    <= req_b;
            end
            else if (pend_reg && dly_reg != 4'h0)
                dly_reg <= dly_reg - 4'h1;
            else if (pend_reg)
            begin
                pend_reg <= 1'b0;
                if (b_reg)
                    cmp_evt.b[ch_reg] <= 1'b1;
                else
                    cmp_evt.a[ch_reg] <= 1'b1;
            end
        end
    end
endmodule

// [sim/tb_ppd_data_regs.sv]
// Self-checking testbench of the pulse pattern data registers
module tb_ppd_data_regs;
    timeunit 1ns;
    timeprecision 1ps;

    logic                     mclk;
    logic                     rst;
    logic [ppd_pkg::AW-1:0]   addr;
    logic [ppd_pkg::DW-1:0]   wdata;
    logic                     wr;
    logic                     rd;
    logic [ppd_pkg::DW-1:0]   rdata;
    ppd_pkg::ppd_cmp_t        cmp_evt;
    logic [ppd_pkg::PINS-1:0] pulse_out;
    logic [ppd_pkg::PINS-1:0] pulse_oe;
    logic                     req;
    logic [1:0]               req_ch;
    logic                     req_b;
    logic [3:0]               req_dly;
    int                       num_errors;
    int                       samples_checked;

    ppd_data_regs ppd_data_regs_i (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .cmp_evt(cmp_evt), .pulse_out(pulse_out), .pulse_oe(pulse_oe));
    ppd_timer_model ppd_timer_model_i (.mclk(mclk), .rst(rst), .req(req), .req_ch(req_ch), .req_b(req_b),
        .req_dly(req_dly), .cmp_evt(cmp_evt));

    // ------------------------------------------------------------------
    // Bus, trigger and compare tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #2;
        check({8'h00, rdata}, {8'h00, exp});
    endtask

    // Returns just after the edge at which the design takes the match
    task automatic fire(input logic [1:0] ch, input logic b, input logic [3:0] dly);
        int n;
        n = 0;
        @(posedge mclk);
        req     <= 1'b1;
        req_ch  <= ch;
        req_b   <= b;
        req_dly <= dly;
        @(posedge mclk);
        req <= 1'b0;
        while (cmp_evt === 8'h00 && n < 40)
        begin
            @(posedge mclk);
            n++;
        end
        check(16'(n == 40), 16'h0000);
    endtask

    task automatic wrap_up;
        $display("Checks made: %0d, errors: %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] exp_rst [12];
        exp_rst = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hF0, 8'h00, 8'h00};
        check(pulse_out, 16'h0000);
        check(pulse_oe, 16'h0000);
        for (int i = 0; i < 12; i++)
            rchk(4'(i), exp_rst[i]);
    endtask

    task automatic t_cur_write;
        wr_reg(ppd_pkg::ADDR_CUR_HI, 8'h5A);
        wr_reg(ppd_pkg::ADDR_CUR_LO, 8'hA5);
        rchk(ppd_pkg::ADDR_CUR_HI, 8'h5A);
        rchk(ppd_pkg::ADDR_CUR_LO, 8'hA5);
        check(pulse_out, 16'h5AA5);
        wr_reg(ppd_pkg::ADDR_EN_HI, 8'hF0);
        wr_reg(ppd_pkg::ADDR_CUR_HI, 8'h0F);
        rchk(ppd_pkg::ADDR_CUR_HI, 8'h5F);
        check(pulse_oe, 16'hF000);
    endtask

    task automatic t_shared;
        wr_reg(ppd_pkg::ADDR_NXT_HI_A, 8'hC3);
        wr_reg(ppd_pkg::ADDR_NXT_HI_B, 8'h77);
        rchk(ppd_pkg::ADDR_NXT_HI_A, 8'hC3);
        rchk(ppd_pkg::ADDR_NXT_HI_B, 8'h00);
        fire(2'h3, 1'b1, 4'h0);
        rchk(ppd_pkg::ADDR_CUR_HI, 8'h5F);
        fire(2'h3, 1'b0, 4'h4);
        rchk(ppd_pkg::ADDR_CUR_HI, 8'hCF);
        check(pulse_out, 16'hCFA5);
    endtask

    task automatic t_codes;
        logic [7:0] prev;
        logic [1:0] c;
        prev = 8'hA5;
        wr_reg(ppd_pkg::ADDR_EN_LO, 8'hFF);
        for (int n = 0; n < 4; n++)
        begin
            c = 2'(n);
            wr_reg(ppd_pkg::ADDR_TRIG_SEL, {4'hF, c, c});
            wr_reg(ppd_pkg::ADDR_NXT_LO_A, {c, 2'h1, c, 2'h2});
            fire(c + 2'h1, 1'b0, 4'h0);
            rchk(ppd_pkg::ADDR_CUR_LO, prev);
            fire(c, 1'b0, 4'(n));
            prev = {c, 2'h1, c, 2'h2};
            rchk(ppd_pkg::ADDR_CUR_LO, prev);
        end
    endtask

    task automatic t_split;
        wr_reg(ppd_pkg::ADDR_EN_HI, 8'h00);
        wr_reg(ppd_pkg::ADDR_EN_LO, 8'h00);
        wr_reg(ppd_pkg::ADDR_CUR_HI, 8'h00);
        wr_reg(ppd_pkg::ADDR_CUR_LO, 8'h00);
        wr_reg(ppd_pkg::ADDR_TRIG_SEL, 8'hE4);
        wr_reg(ppd_pkg::ADDR_NXT_HI_A, 8'hA5);
        wr_reg(ppd_pkg::ADDR_NXT_HI_B, 8'h3C);
        wr_reg(ppd_pkg::ADDR_NXT_LO_A, 8'h96);
        wr_reg(ppd_pkg::ADDR_NXT_LO_B, 8'h81);
        rchk(ppd_pkg::ADDR_NXT_HI_A, 8'hAF);
        rchk(ppd_pkg::ADDR_NXT_HI_B, 8'hFC);
        rchk(ppd_pkg::ADDR_NXT_LO_A, 8'h9F);
        rchk(ppd_pkg::ADDR_NXT_LO_B, 8'hF1);
        wr_reg(ppd_pkg::ADDR_EN_HI, 8'hFF);
        wr_reg(ppd_pkg::ADDR_EN_LO, 8'hFF);
        fire(2'h3, 1'b0, 4'h0);
        rchk(ppd_pkg::ADDR_CUR_HI, 8'hA0);
        fire(2'h2, 1'b0, 4'h2);
        rchk(ppd_pkg::ADDR_CUR_HI, 8'hAC);
        fire(2'h1, 1'b0, 4'h0);
        rchk(ppd_pkg::ADDR_CUR_LO, 8'h90);
        fire(2'h0, 1'b0, 4'h1);
        rchk(ppd_pkg::ADDR_CUR_LO, 8'h91);
        wr_reg(ppd_pkg::ADDR_MODE, 8'hA0);
        rchk(ppd_pkg::ADDR_MODE, 8'hA0);
        check(pulse_out, 16'hA39E);
        wr_reg(ppd_pkg::ADDR_MODE, 8'hF8);
        wr_reg(ppd_pkg::ADDR_NXT_HI_A, 8'h50);
        fire(2'h3, 1'b1, 4'h0);
        rchk(ppd_pkg::ADDR_CUR_HI, 8'h5C);
    endtask

    // Next-pattern write lands on the same edge as the trigger
    task automatic t_collide;
        wr_reg(ppd_pkg::ADDR_MODE, 8'hF0);
        wr_reg(ppd_pkg::ADDR_TRIG_SEL, 8'hFF);
        wr_reg(ppd_pkg::ADDR_NXT_HI_A, 8'h11);
        @(posedge mclk);
        req     <= 1'b1;
        req_ch  <= 2'h3;
        req_b   <= 1'b0;
        req_dly <= 4'h0;
        @(posedge mclk);
        req <= 1'b0;
        @(posedge mclk);
        addr  <= ppd_pkg::ADDR_NXT_HI_A;
        wdata <= 8'h22;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        rchk(ppd_pkg::ADDR_CUR_HI, 8'h11);
        rchk(ppd_pkg::ADDR_NXT_HI_A, 8'h22);
        fire(2'h3, 1'b0, 4'h0);
        rchk(ppd_pkg::ADDR_CUR_HI, 8'h22);
    endtask

    // ------------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    initial
    begin
        num_errors = 0;
        samples_checked = 0;
        rst = 1'b1;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        req = 1'b0;
        req_ch = 2'h0;
        req_b = 1'b0;
        req_dly = 4'h0;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        t_reset;
        t_cur_write;
        t_shared;
        t_codes;
        t_split;
        t_collide;
        wrap_up;
    end

    // The whole sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge mclk);
        num_errors++;
        wrap_up;
    end
endmodule
